// *** inc/vrb_cfg.svh ***
`ifndef VRB_CFG_SVH
`define VRB_CFG_SVH
// Contract
// - Receiver control bus address is 0x90.
// - Host is bus master, receiver slave.
// - On interrupt host reads status, then acts.
// - Bring-up starts by pulsing receiver reset.
// - Host reads ID memory to check contents.
// - Write-protect held low while writing memory.
// - Afterwards write-protect high, memory lines released.
// - Host then writes receiver configuration registers.
// - Both hot-plug enables driven low afterwards.
// - Port 1 is selected first.
// - Poll interrupt; swap ports every three seconds.
// - On source: authenticate, read format, set colour.

// Clock and timing
`define VRB_CLK_KHZ        100000
`define VRB_I2C_KHZ        1000
`define VRB_QTR_CYC        ((`VRB_CLK_KHZ + 4 * `VRB_I2C_KHZ - 1) / (4 * `VRB_I2C_KHZ))
`define VRB_RST_HOLD_US    10
`define VRB_RST_HOLD_CYC   ((`VRB_RST_HOLD_US * `VRB_CLK_KHZ + 999) / 1000)
`define VRB_RST_WAIT_US    30
`define VRB_RST_WAIT_CYC   ((`VRB_RST_WAIT_US * `VRB_CLK_KHZ + 999) / 1000)
`define VRB_PORT_SWITCH_MS 3000

// Bus addresses
`define VRB_RX_ADDR        8'h90
`define VRB_IDM_ADDR       8'hA0
`define VRB_RD_BIT         8'h01

// Identification memory check location and expected byte
`define VRB_IDM_CHK_OFS    8'h7F
`define VRB_IDM_CHK_VAL    8'h00

// Receiver register offsets and values
`define VRB_REG_INIT       8'h01
`define VRB_INIT_VAL       8'h00
`define VRB_REG_PORT       8'h02
`define VRB_REG_STAT       8'h03
`define VRB_STAT_SRC_BIT   0
`define VRB_REG_AUTH       8'h04
`define VRB_AUTH_GO        8'h01
`define VRB_AUTH_DONE_BIT  1
`define VRB_REG_FMT        8'h05
`define VRB_FMT_CS_LSB     0
`define VRB_REG_CSC        8'h06
`define VRB_OUT_CS         2'h0
`endif

// *** inc/vrb_pkg.sv ***
package vrb_pkg;
	// Bus operations the bit engine performs
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP  = 2'h1,
		OP_WRB   = 2'h2,
		OP_RDB   = 2'h3
	} vrb_op_e;

	typedef struct packed {
		vrb_op_e    op;
		logic [7:0] data;
		logic       nack;
	} vrb_cmd_s;

	// One register access: bus 0 is receiver, 1 is ID memory
	typedef struct packed {
		logic       rd;
		logic       bus;
		logic [7:0] addr;
		logic [7:0] wd;
	} vrb_tx_s;

	typedef enum logic [15:0] {
		ST_IDLE     = 16'h0001,
		ST_RST      = 16'h0002,
		ST_WAIT     = 16'h0004,
		ST_IDM_RD   = 16'h0008,
		ST_IDM_WR   = 16'h0010,
		ST_IDM_END  = 16'h0020,
		ST_INIT     = 16'h0040,
		ST_HPD      = 16'h0080,
		ST_SEL      = 16'h0100,
		ST_POLL     = 16'h0200,
		ST_STAT     = 16'h0400,
		ST_AUTH     = 16'h0800,
		ST_AUTH_CHK = 16'h1000,
		ST_FMT      = 16'h2000,
		ST_CSC      = 16'h4000,
		ST_RUN      = 16'h8000
	} vrb_st_e;
endpackage

// *** verilog/vrb_i2c_eng.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vrb_cfg.svh"
module vrb_i2c_eng
	import vrb_pkg::*;
(
	input  wire logic     clk_in,
	input  wire logic     rst_b_in,
	input  wire logic     cmd_valid_in,
	input  wire vrb_cmd_s cmd_in,
	input  wire logic     scl_in,
	input  wire logic     sda_in,
	output logic          done_out,
	output logic          ack_out,
	output logic [7:0]    rdata_out,
	output logic          scl_oe_out,
	output logic          sda_oe_out
);
	logic        scl_s1_r;
	logic        scl_s2_r;
	logic        sda_s1_r;
	logic        sda_s2_r;
	logic        busy_r;
	logic        nack_r;
	vrb_op_e     op_r;
	logic [7:0]  sh_r;
	logic [3:0]  bit_r;
	logic [1:0]  ph_r;
	logic [15:0] q_r;
	logic        adv;
	logic        last;
	logic        is_byte;
	logic        scl_oe_nxt;
	logic        sda_oe_nxt;

	// Line synchronisers
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
		end
	end

	// Quarter-bit tick, held while a slave stretches the clock
	assign is_byte = (op_r == OP_WRB) || (op_r == OP_RDB);
	assign adv = busy_r && (q_r == 16'(`VRB_QTR_CYC - 1)) && !(ph_r == 2'd1 && !scl_s2_r);
	assign last = (ph_r == 2'd3) && (!is_byte || bit_r == 4'd8);
	assign rdata_out = sh_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			q_r <= 16'h0000;
		end else if (!busy_r || adv) begin
			q_r <= 16'h0000;
		end else if (q_r != 16'(`VRB_QTR_CYC - 1)) begin
			q_r <= q_r + 16'h0001;
		end
	end

	// Operation sequencing; the host is always the master here
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_r <= 1'b0;
			op_r <= OP_STOP;
			sh_r <= 8'h00;
			nack_r <= 1'b0;
			bit_r <= 4'h0;
			ph_r <= 2'h0;
			done_out <= 1'b0;
			ack_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (!busy_r && cmd_valid_in) begin
				busy_r <= 1'b1;
				op_r <= cmd_in.op;
				if (cmd_in.op == OP_WRB) begin
					sh_r <= cmd_in.data; // Read byte survives the closing stop
				end
				nack_r <= cmd_in.nack;
				bit_r <= 4'h0;
				ph_r <= 2'h0;
			end else if (adv) begin
				ph_r <= ph_r + 2'd1;
				if (ph_r == 2'd2 && is_byte) begin
					if (bit_r == 4'd8) begin
						ack_out <= !sda_s2_r;
					end else begin
						sh_r <= {sh_r[6:0], sda_s2_r};
					end
				end
				if (ph_r == 2'd3 && is_byte) begin
					bit_r <= bit_r + 4'd1;
				end
				if (last) begin
					busy_r <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end

	// Line levels per phase; byte data only moves while the clock is low, start and stop move it with the clock high
	always_comb begin
		scl_oe_nxt = scl_oe_out;
		sda_oe_nxt = sda_oe_out;
		case (op_r)
			OP_START: begin
				scl_oe_nxt = (ph_r == 2'd0) || (ph_r == 2'd3);
				sda_oe_nxt = ph_r[1];
			end
			OP_STOP: begin
				scl_oe_nxt = (ph_r == 2'd0);
				sda_oe_nxt = (ph_r <= 2'd1);
			end
			default: begin
				scl_oe_nxt = (ph_r == 2'd0) || (ph_r == 2'd3);
				if (ph_r == 2'd0 && bit_r == 4'd8) begin
					sda_oe_nxt = (op_r == OP_RDB) && !nack_r;
				end else if (ph_r == 2'd0) begin
					sda_oe_nxt = (op_r == OP_WRB) && !sh_r[7];
				end
			end
		endcase
	end

	// Lines hold their last level between operations
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (busy_r) begin
			scl_oe_out <= scl_oe_nxt;
			sda_oe_out <= sda_oe_nxt;
		end
	end
endmodule
`default_nettype wire

// *** verilog/vrb_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vrb_cfg.svh"
module vrb_host
	import vrb_pkg::*;
#(
	parameter int unsigned P_SWITCH_CYC = `VRB_PORT_SWITCH_MS * `VRB_CLK_KHZ
)
(
	input  wire logic  clk_in,
	input  wire logic  rst_b_in,
	input  wire logic  start_in,
	output logic       rx_rst_b_out,
	input  wire logic  rx_int_b_in,
	input  wire logic  rx_scl_in,
	output logic       rx_scl_out,
	output logic       rx_scl_oe_out,
	input  wire logic  rx_sda_in,
	output logic       rx_sda_out,
	output logic       rx_sda_oe_out,
	input  wire logic  idm_scl_in,
	output logic       idm_scl_out,
	output logic       idm_scl_oe_out,
	input  wire logic  idm_sda_in,
	output logic       idm_sda_out,
	output logic       idm_sda_oe_out,
	output logic       id_memory_write_protect_out,
	output logic       port1_hotplug_enable_n_out,
	output logic       port2_hotplug_enable_n_out,
	output logic       active_port_out,
	output logic       source_ok_out,
	output logic [7:0] color_fmt_out,
	output logic       busy_out,
	output logic       err_out
);
	vrb_st_e     st_r;
	vrb_st_e     st_prev_r;
	logic [15:0] ent_r;
	logic [31:0] sw_r;
	logic        sw_exp;
	logic        int_s1_r;
	logic        int_s2_r;
	logic        iss_r;
	logic        req_r;
	logic        tx_st;
	vrb_tx_s     req_tx;
	vrb_tx_s     tx_r;
	logic [2:0]  step_r;
	logic        txb_r;
	logic        cmd_v_r;
	vrb_cmd_s    cmd_r;
	logic        tx_done_r;
	logic        tx_nak_r;
	logic [7:0]  tx_rdata_r;
	logic        tx_last;
	logic        ack_chk;
	logic        eng_done;
	logic        eng_ack;
	logic        rx_done;
	logic        rx_ack;
	logic [7:0]  rx_rd;
	logic        idm_done;
	logic        idm_ack;
	logic [7:0]  idm_rd;
	logic        port_r;
	logic        src_r;
	logic [7:0]  fmt_r;
	logic        err_r;
	logic        busy_r;
	logic        rst_b_r;
	logic        wp_r;
	logic        hpd1_r;
	logic        hpd2_r;
	logic        lo_r;

	// Splits one register access into bus operations
	function automatic vrb_cmd_s tx_cmd(input vrb_tx_s t, input logic [2:0] step);
		vrb_cmd_s   c;
		logic [7:0] dev;
		c.op = OP_STOP;
		c.data = 8'h00;
		c.nack = 1'b0;
		dev = t.bus ? `VRB_IDM_ADDR : `VRB_RX_ADDR;
		case (step)
			3'd0: c.op = OP_START;
			3'd1: begin
				c.op = OP_WRB;
				c.data = dev;
			end
			3'd2: begin
				c.op = OP_WRB;
				c.data = t.addr;
			end
			3'd3: begin
				c.op = t.rd ? OP_START : OP_WRB;
				c.data = t.wd;
			end
			3'd4: begin
				if (t.rd) begin
					c.op = OP_WRB;
					c.data = dev | `VRB_RD_BIT;
				end
			end
			3'd5: begin
				c.op = OP_RDB;
				c.nack = 1'b1;
			end
			default: c.op = OP_STOP;
		endcase
		return c;
	endfunction

	// Interrupt line synchroniser; the line is active low
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			int_s1_r <= 1'b1;
			int_s2_r <= 1'b1;
		end else begin
			int_s1_r <= rx_int_b_in;
			int_s2_r <= int_s1_r;
		end
	end

	// Engine on the receiver control bus
	vrb_i2c_eng u_rx_eng (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.cmd_valid_in (cmd_v_r && !tx_r.bus),
		.cmd_in       (cmd_r),
		.scl_in       (rx_scl_in),
		.sda_in       (rx_sda_in),
		.done_out     (rx_done),
		.ack_out      (rx_ack),
		.rdata_out    (rx_rd),
		.scl_oe_out   (rx_scl_oe_out),
		.sda_oe_out   (rx_sda_oe_out)
	);

	// Engine on the identification memory bus
	vrb_i2c_eng u_idm_eng (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.cmd_valid_in (cmd_v_r && tx_r.bus),
		.cmd_in       (cmd_r),
		.scl_in       (idm_scl_in),
		.sda_in       (idm_sda_in),
		.done_out     (idm_done),
		.ack_out      (idm_ack),
		.rdata_out    (idm_rd),
		.scl_oe_out   (idm_scl_oe_out),
		.sda_oe_out   (idm_sda_oe_out)
	);

	// Access sequencer over whichever engine the access targets
	assign eng_done = tx_r.bus ? idm_done : rx_done;
	assign eng_ack = tx_r.bus ? idm_ack : rx_ack;
	assign tx_last = step_r == (tx_r.rd ? 3'd6 : 3'd4);
	assign ack_chk = (step_r == 3'd1) || (step_r == 3'd2) ||
		(step_r == 3'd3 && !tx_r.rd) || (step_r == 3'd4 && tx_r.rd);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			txb_r <= 1'b0;
			tx_r <= '0;
			step_r <= 3'h0;
			cmd_v_r <= 1'b0;
			cmd_r <= '0;
			tx_done_r <= 1'b0;
			tx_nak_r <= 1'b0;
			tx_rdata_r <= 8'h00;
		end else begin
			cmd_v_r <= 1'b0;
			tx_done_r <= 1'b0;
			if (!txb_r && req_r) begin
				txb_r <= 1'b1;
				tx_r <= req_tx;
				step_r <= 3'h0;
				cmd_r <= tx_cmd(req_tx, 3'd0);
				cmd_v_r <= 1'b1;
				tx_nak_r <= 1'b0;
			end else if (txb_r && eng_done) begin
				if (ack_chk && !eng_ack) begin
					tx_nak_r <= 1'b1;
				end
				if (tx_last) begin
					txb_r <= 1'b0;
					tx_done_r <= 1'b1;
					tx_rdata_r <= tx_r.bus ? idm_rd : rx_rd;
				end else begin
					step_r <= step_r + 3'd1;
					cmd_r <= tx_cmd(tx_r, step_r + 3'd1);
					cmd_v_r <= 1'b1;
				end
			end
		end
	end

	// Access wanted in each state
	always_comb begin
		req_tx = '0;
		tx_st = 1'b1;
		case (st_r)
			ST_IDM_RD: begin
				req_tx.rd = 1'b1;
				req_tx.bus = 1'b1;
				req_tx.addr = `VRB_IDM_CHK_OFS;
			end
			ST_IDM_WR: begin
				req_tx.bus = 1'b1;
				req_tx.addr = `VRB_IDM_CHK_OFS;
				req_tx.wd = `VRB_IDM_CHK_VAL;
			end
			ST_INIT: begin
				req_tx.addr = `VRB_REG_INIT;
				req_tx.wd = `VRB_INIT_VAL;
			end
			ST_SEL: begin
				req_tx.addr = `VRB_REG_PORT;
				req_tx.wd = {7'h00, port_r};
			end
			ST_STAT: begin
				req_tx.rd = 1'b1;
				req_tx.addr = `VRB_REG_STAT;
			end
			ST_AUTH: begin
				req_tx.addr = `VRB_REG_AUTH;
				req_tx.wd = `VRB_AUTH_GO;
			end
			ST_AUTH_CHK: begin
				req_tx.rd = 1'b1;
				req_tx.addr = `VRB_REG_AUTH;
			end
			ST_FMT: begin
				req_tx.rd = 1'b1;
				req_tx.addr = `VRB_REG_FMT;
			end
			ST_CSC: begin
				req_tx.addr = `VRB_REG_CSC;
				req_tx.wd = {4'h0, `VRB_OUT_CS, fmt_r[`VRB_FMT_CS_LSB +: 2]};
			end
			default: tx_st = 1'b0;
		endcase
	end

	// Cycles spent in the current state
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_prev_r <= ST_IDLE;
			ent_r <= 16'h0000;
		end else begin
			st_prev_r <= st_r;
			if (st_r != st_prev_r) begin
				ent_r <= 16'h0000;
			end else if (ent_r != 16'hFFFF) begin
				ent_r <= ent_r + 16'h0001;
			end
		end
	end

	// Port swap timer, restarted whenever a port is selected
	assign sw_exp = sw_r >= 32'(P_SWITCH_CYC - 1);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sw_r <= 32'h0000_0000;
		end else if (st_r == ST_SEL) begin
			sw_r <= 32'h0000_0000;
		end else if (!sw_exp) begin
			sw_r <= sw_r + 32'h0000_0001;
		end
	end

	// Bring-up and port search sequence
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= ST_IDLE;
			iss_r <= 1'b0;
			req_r <= 1'b0;
			port_r <= 1'b0;
			src_r <= 1'b0;
			fmt_r <= 8'h00;
			err_r <= 1'b0;
		end else begin
			req_r <= 1'b0;
			if (tx_st && !iss_r) begin
				req_r <= 1'b1;
				iss_r <= 1'b1;
			end
			if (tx_done_r) begin
				iss_r <= 1'b0;
				err_r <= err_r | tx_nak_r;
			end
			case (st_r)
				ST_IDLE: begin
					if (start_in) begin
						st_r <= ST_RST;
						err_r <= 1'b0;
						src_r <= 1'b0;
					end
				end
				ST_RST: begin
					if (ent_r == 16'(`VRB_RST_HOLD_CYC - 1)) begin
						st_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (ent_r == 16'(`VRB_RST_WAIT_CYC - 1)) begin
						st_r <= ST_IDM_RD;
					end
				end
				ST_IDM_RD: begin
					if (tx_done_r && tx_rdata_r != `VRB_IDM_CHK_VAL) begin
						st_r <= ST_IDM_WR;
					end else if (tx_done_r) begin
						st_r <= ST_IDM_END;
					end
				end
				ST_IDM_WR: begin
					if (tx_done_r) begin
						st_r <= ST_IDM_END;
					end
				end
				ST_IDM_END: st_r <= ST_INIT;
				ST_INIT: begin
					if (tx_done_r) begin
						st_r <= ST_HPD;
					end
				end
				ST_HPD: begin
					port_r <= 1'b0;
					st_r <= ST_SEL;
				end
				ST_SEL: begin
					if (tx_done_r) begin
						st_r <= ST_POLL;
					end
				end
				ST_POLL: begin
					if (!int_s2_r) begin
						st_r <= ST_STAT;
					end else if (sw_exp) begin
						port_r <= ~port_r;
						st_r <= ST_SEL;
					end
				end
				ST_STAT: begin
					if (tx_done_r && tx_rdata_r[`VRB_STAT_SRC_BIT]) begin
						src_r <= 1'b1;
						st_r <= ST_AUTH;
					end else if (tx_done_r) begin
						src_r <= 1'b0;
						st_r <= ST_POLL;
					end
				end
				ST_AUTH: begin
					if (tx_done_r) begin
						st_r <= ST_AUTH_CHK;
					end
				end
				ST_AUTH_CHK: begin
					if (tx_done_r && tx_rdata_r[`VRB_AUTH_DONE_BIT]) begin
						st_r <= ST_FMT;
					end
				end
				ST_FMT: begin
					if (tx_done_r) begin
						fmt_r <= tx_rdata_r;
						st_r <= ST_CSC;
					end
				end
				ST_CSC: begin
					if (tx_done_r) begin
						st_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!int_s2_r) begin
						st_r <= ST_STAT;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Pin levels toward the receiver card
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_b_r <= 1'b0;
			wp_r <= 1'b1;
			hpd1_r <= 1'b1;
			hpd2_r <= 1'b1;
			lo_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			rst_b_r <= !(st_r == ST_IDLE || st_r == ST_RST);
			wp_r <= (st_r != ST_IDM_WR);
			lo_r <= 1'b0;
			busy_r <= !(st_r == ST_IDLE || st_r == ST_RUN);
			if (st_r == ST_HPD) begin
				hpd1_r <= 1'b0;
				hpd2_r <= 1'b0;
			end else if (st_r == ST_RST) begin
				hpd1_r <= 1'b1;
				hpd2_r <= 1'b1;
			end
		end
	end

	// Open-drain lines only ever pull low
	assign rx_scl_out = lo_r;
	assign rx_sda_out = lo_r;
	assign idm_scl_out = lo_r;
	assign idm_sda_out = lo_r;
	assign rx_rst_b_out = rst_b_r;
	assign id_memory_write_protect_out = wp_r;
	assign port1_hotplug_enable_n_out = hpd1_r;
	assign port2_hotplug_enable_n_out = hpd2_r;
	assign active_port_out = port_r;
	assign source_ok_out = src_r;
	assign color_fmt_out = fmt_r;
	assign busy_out = busy_r;
	assign err_out = err_r;
endmodule
`default_nettype wire

// *** verif/vrb_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module vrb_rx_model #(
	parameter logic [7:0] P_ADDR = 8'h90
)(
	input  wire logic rst_b_in,
	input  wire logic wp_in,
	input  wire logic stretch_in,
	input  wire logic irq_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_oe_out,
	output logic      sda_oe_out,
	output logic      int_b_out
);
	logic [7:0] mem [256];
	logic [7:0] sh, ptr;
	logic       act = 1'b0, tx = 1'b0, tx_nxt = 1'b0, nack = 1'b0, dr = 1'b0, st = 1'b0;
	int         bc = 0, nb = 0;
	// Pending event is a low level, never shown while held in reset
	assign int_b_out = !(rst_b_in && irq_in);
	assign scl_oe_out = st;
	assign sda_oe_out = dr;
	// Start or repeated start opens a transfer
	always @(negedge sda_in) if (scl_in && rst_b_in) begin
		act = 1'b1;
		tx = 1'b0;
		bc = 0;
		nb = 0;
	end
	// Stop, or the reset pin low, ends it and frees the data line
	always @(posedge sda_in or negedge rst_b_in) if (scl_in || !rst_b_in) begin
		act = 1'b0;
		dr = 1'b0;
	end
	// Sample on the rising clock edge
	always @(posedge scl_in) if (act) begin
		if (bc < 8) sh = {sh[6:0], sda_in};
		else nack = sda_in;
		bc = bc + 1;
	end
	// Acknowledge, store and shift out on the falling edge; may hold the clock low
	always @(negedge scl_in) if (act) begin
		dr = 1'b0;
		if (bc == 8 && !tx) begin
			if (nb == 0 && sh[7:1] != P_ADDR[7:1]) act = 1'b0;
			else dr = 1'b1;
			if (nb == 0) tx_nxt = sh[0];
			if (nb == 1) ptr = sh;
			if (nb > 1 && !wp_in) mem[ptr] = (ptr == 8'h02) ? (sh & 8'h01) : sh;
			if (nb > 1 && P_ADDR == 8'h90 && ptr == 8'h04 && sh[0]) mem[ptr] = sh | 8'h02;
			if (nb > 1) ptr = ptr + 8'h01;
			nb = nb + 1;
			if (stretch_in) st = 1'b1;
			if (stretch_in) st <= #3000 1'b0;
		end else if (bc == 9) begin
			bc = 0;
			if (tx && nack) act = 1'b0;
			if (tx && !nack) ptr = ptr + 8'h01;
			tx = tx_nxt;
			if (act && tx) dr = !mem[ptr][7];
		end else if (tx && bc < 8) dr = !mem[ptr][7 - bc];
	end
endmodule
`default_nettype wire

// *** verif/vrb_host_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vrb_cfg.svh"
module vrb_host_assertions #(
	parameter int unsigned P_SWITCH_CYC = 20000
)(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic rx_rst_b_out,
	input wire logic rx_int_b_in,
	input wire logic rx_scl_oe_out,
	input wire logic rx_sda_oe_out,
	input wire logic idm_scl_oe_out,
	input wire logic idm_sda_oe_out,
	input wire logic id_memory_write_protect_out,
	input wire logic port1_hotplug_enable_n_out,
	input wire logic port2_hotplug_enable_n_out,
	input wire logic active_port_out,
	input wire logic source_ok_out,
	input wire logic busy_out
);
	localparam int unsigned HOLD_LO = `VRB_RST_HOLD_CYC - 2;
	localparam int unsigned HOLD_HI = `VRB_RST_HOLD_CYC + 2;
	int unsigned rst_cnt, quiet_cnt;
	logic        port_r;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// Cycles the receiver reset has been held since bring-up began
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) rst_cnt <= 0;
		else if (!busy_out) rst_cnt <= 0;
		else if (!rx_rst_b_out) rst_cnt <= rst_cnt + 1;
	end
	// Cycles since hot-plug went live or the active port last changed
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			port_r <= 1'b0;
			quiet_cnt <= 0;
		end else begin
			port_r <= active_port_out;
			if (port1_hotplug_enable_n_out || active_port_out != port_r) quiet_cnt <= 0;
			else quiet_cnt <= quiet_cnt + 1;
		end
	end
	// Interrupt held low while idling in the run state
	sequence s_run_irq;
		(!busy_out && !port1_hotplug_enable_n_out && !rx_int_b_in)[*4];
	endsequence
	chk_rst_hold: assert property ($rose(rx_rst_b_out) |-> rst_cnt >= HOLD_LO && rst_cnt <= HOLD_HI)
		else $error("receiver reset pulse length wrong");
	chk_rst_quiet: assert property (!rx_rst_b_out |-> !rx_scl_oe_out && !rx_sda_oe_out
		&& !idm_scl_oe_out && !idm_sda_oe_out)
		else $error("bus driven while receiver in reset");
	chk_wp_rx_quiet: assert property (!id_memory_write_protect_out |-> !rx_scl_oe_out
		&& !rx_sda_oe_out && port1_hotplug_enable_n_out)
		else $error("receiver traffic while memory unprotected");
	chk_idm_release: assert property (!port1_hotplug_enable_n_out |-> id_memory_write_protect_out
		&& !idm_scl_oe_out && !idm_sda_oe_out)
		else $error("memory lines not released");
	chk_hpd_pair: assert property (port1_hotplug_enable_n_out == port2_hotplug_enable_n_out)
		else $error("hot-plug enables differ");
	chk_port1_first: assert property ($fell(port1_hotplug_enable_n_out) |-> !active_port_out)
		else $error("first port not port 1");
	chk_swap_wait: assert property (active_port_out != port_r |-> quiet_cnt >= P_SWITCH_CYC)
		else $error("port swapped too early");
	chk_irq_read: assert property (s_run_irq |-> ##[0:4] busy_out)
		else $error("interrupt not serviced");
	chk_run_source: assert property ($fell(busy_out) |-> source_ok_out)
		else $error("run entered without source");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int unsigned SW = 20000;
	logic       clk_in = 1'b0, rst_b_in = 1'b0, start_in = 1'b0, rx_irq = 1'b0, rx_str = 1'b0;
	logic       rx_rst_b, rx_int_b, h_rscl, h_rsda, h_iscl, h_isda, wp, hp1_n, hp2_n;
	logic       act_port, src_ok, busy, err, m_rscl, m_rsda, m_iscl, m_isda;
	logic [7:0] fmt;
	int         n_mismatch = 0, checks = 0, cyc = 0, t0 = 0;
	// Open-drain lines with pull-ups: low while any party drives
	wire rx_scl = !h_rscl && !m_rscl;
	wire rx_sda = !h_rsda && !m_rsda;
	wire id_scl = !h_iscl && !m_iscl;
	wire id_sda = !h_isda && !m_isda;
	vrb_host #(.P_SWITCH_CYC(SW)) u_vrb_host (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(start_in), .rx_rst_b_out(rx_rst_b),
		.rx_int_b_in(rx_int_b), .rx_scl_in(rx_scl), .rx_scl_out(), .rx_scl_oe_out(h_rscl),
		.rx_sda_in(rx_sda), .rx_sda_out(), .rx_sda_oe_out(h_rsda), .idm_scl_in(id_scl),
		.idm_scl_out(), .idm_scl_oe_out(h_iscl), .idm_sda_in(id_sda), .idm_sda_out(),
		.idm_sda_oe_out(h_isda), .id_memory_write_protect_out(wp),
		.port1_hotplug_enable_n_out(hp1_n), .port2_hotplug_enable_n_out(hp2_n),
		.active_port_out(act_port), .source_ok_out(src_ok), .color_fmt_out(fmt),
		.busy_out(busy), .err_out(err)
	);
	// Receiver at its control address, reset by the host
	vrb_rx_model #(.P_ADDR(8'h90)) u_rx_dev (
		.rst_b_in(rx_rst_b), .wp_in(1'b0), .stretch_in(rx_str), .irq_in(rx_irq), .scl_in(rx_scl),
		.sda_in(rx_sda), .scl_oe_out(m_rscl), .sda_oe_out(m_rsda), .int_b_out(rx_int_b)
	);
	// Slow ID memory, stretching the clock on every byte it receives
	vrb_rx_model #(.P_ADDR(8'hA0)) u_id_mem (
		.rst_b_in(rst_b_in), .wp_in(wp), .stretch_in(1'b1), .irq_in(1'b0), .scl_in(id_scl),
		.sda_in(id_sda), .scl_oe_out(m_iscl), .sda_oe_out(m_isda), .int_b_out()
	);
	// Clock and hang guard
	initial forever #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 100000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic tick();
		@(posedge clk_in);
		#1;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_reset();
		repeat (4) tick();
		check("reset_pins", {rx_rst_b, wp, hp1_n, hp2_n, act_port, src_ok, busy, err}, 8'h70);
		check("reset_fmt", fmt, 8'h00);
		rst_b_in = 1'b1;
	endtask
	task automatic t_idm();
		u_id_mem.mem[8'h7F] = 8'h5A;
		u_rx_dev.mem[8'h01] = 8'hFF;
		u_rx_dev.mem[8'h02] = 8'hFF;
		u_rx_dev.mem[8'h04] = 8'h00;
		u_rx_dev.mem[8'h06] = 8'hFF;
		tick();
		start_in = 1'b1;
		tick();
		start_in = 1'b0;
		tick();
		check("rx_in_reset", 8'(rx_rst_b), 8'h00);
		wait (!wp);
		wait (wp);
		tick();
		check("idm_updated", u_id_mem.mem[8'h7F], 8'h00);
		check("idm_released", 8'({h_iscl, h_isda}), 8'h00);
		check("rx_not_yet", u_rx_dev.mem[8'h01], 8'hFF);
	endtask
	task automatic t_init();
		wait (!hp1_n);
		t0 = cyc;
		check("init_reg", u_rx_dev.mem[8'h01], 8'h00);
		check("hpd_pins", 8'({hp1_n, hp2_n}), 8'h00);
		wait (u_rx_dev.mem[8'h02] == 8'h00);
		check("first_port", 8'(act_port), 8'h00);
		check("no_nack", 8'(err), 8'h00);
	endtask
	task automatic t_swap();
		wait (act_port);
		check("swap_early", 8'(cyc - t0 >= SW), 8'h01);
		check("swap_late", 8'(cyc - t0 <= SW + 4000), 8'h01);
		wait (u_rx_dev.mem[8'h02] == 8'h01);
		check("second_port", 8'(act_port), 8'h01);
	endtask
	task automatic t_source();
		u_rx_dev.mem[8'h03] = 8'h01;
		u_rx_dev.mem[8'h05] = 8'h0E;
		rx_str = 1'b1;
		tick();
		rx_irq = 1'b1;
		wait (src_ok);
		tick();
		rx_irq = 1'b0;
		wait (!busy);
		check("auth_reg", u_rx_dev.mem[8'h04], 8'h03);
		check("csc_reg", u_rx_dev.mem[8'h06], 8'h02);
		check("fmt_seen", fmt, 8'h0E);
		check("run_err", 8'(err), 8'h00);
	endtask
	task automatic t_nosrc();
		u_rx_dev.mem[8'h03] = 8'h00;
		tick();
		rx_irq = 1'b1;
		wait (busy);
		wait (!src_ok);
		tick();
		rx_irq = 1'b0;
		repeat (10) tick();
		check("back_to_poll", 8'(busy), 8'h01);
	endtask
	// Main sequence
	initial begin
		t_reset();
		t_idm();
		t_init();
		t_swap();
		t_source();
		t_nosrc();
		print_verdict();
	end
endmodule
bind vrb_host vrb_host_assertions #(.P_SWITCH_CYC(P_SWITCH_CYC)) u_chk (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .rx_rst_b_out(rx_rst_b_out), .rx_int_b_in(rx_int_b_in),
	.rx_scl_oe_out(rx_scl_oe_out), .rx_sda_oe_out(rx_sda_oe_out),
	.idm_scl_oe_out(idm_scl_oe_out), .idm_sda_oe_out(idm_sda_oe_out),
	.id_memory_write_protect_out(id_memory_write_protect_out),
	.port1_hotplug_enable_n_out(port1_hotplug_enable_n_out),
	.port2_hotplug_enable_n_out(port2_hotplug_enable_n_out),
	.active_port_out(active_port_out), .source_ok_out(source_ok_out), .busy_out(busy_out)
);
`default_nettype wire
